// ==== core/pcl_cv_rom.sv ====
// Fixed preset lists and factory defaults of the variable bank
module pcl_cv_rom (
   input logic [7:0] presetSel, // Preset number, zero for none
   input logic [7:0] cvIndex, // Variable index
   output logic [7:0] cvValue // Value to load
);
   logic [7:0] factory;
   logic hit;
   logic [7:0] presetVal;

   // Factory default of each variable
   always_comb begin
      case (cvIndex)
         8'h01: factory = 8'h03;
         8'h02: factory = 8'h01;
         8'h03: factory = 8'h02;
         8'h04: factory = 8'h01;
         8'h05: factory = 8'h01;
         8'h06: factory = 8'h01;
         8'h1D: factory = 8'h04;
         default: factory = 8'h00;
      endcase
   end

   // Preset lists keyed by preset and index
   always_comb begin
      hit = 1'b1;
      presetVal = 8'h00;
      case ({presetSel, cvIndex})
         {8'h0A, 8'h02}: presetVal = 8'h04;
         {8'h0A, 8'h03}: presetVal = 8'h06;
         {8'h0A, 8'h04}: presetVal = 8'h02;
         {8'h0A, 8'h05}: presetVal = 8'hFC;
         {8'h0A, 8'h06}: presetVal = 8'h55;
         {8'h0A, 8'h09}: presetVal = 8'h5F;
         {8'h0A, 8'h0A}: presetVal = 8'h80;
         {8'h0A, 8'h1D}: presetVal = 8'h06;
         {8'h0A, 8'h38}: presetVal = 8'h21;
         {8'h0A, 8'h69}: presetVal = pcl_pkg::CUST_ID_A;
         {8'h0A, 8'h6A}: presetVal = pcl_pkg::CUST_ID_B;
         {8'h0A, 8'h71}: presetVal = 8'hFF;
         {8'h0A, 8'h7A}: presetVal = 8'h1F;
         {8'h0A, 8'h90}: presetVal = 8'h80;
         {8'h0A, 8'h92}: presetVal = 8'h1E;
         {8'h0A, 8'h96}: presetVal = 8'hFF;
         {8'h0B, 8'h03}: presetVal = 8'h03;
         {8'h0B, 8'h04}: presetVal = 8'h02;
         {8'h0B, 8'h09}: presetVal = 8'h58;
         {8'h0B, 8'h0D}: presetVal = 8'h01;
         {8'h0B, 8'h38}: presetVal = 8'h3D;
         {8'h0B, 8'h3A}: presetVal = 8'hAA;
         {8'h0B, 8'h70}: presetVal = 8'h24;
         {8'h0B, 8'h7C}: presetVal = 8'h80;
         {8'h0B, 8'h98}: presetVal = 8'h40;
         {8'h0C, 8'h03}: presetVal = 8'h0F;
         {8'h0C, 8'h04}: presetVal = 8'h08;
         {8'h0C, 8'h06}: presetVal = 8'h78;
         {8'h0C, 8'h23}: presetVal = 8'h0C;
         {8'h0C, 8'h24}: presetVal = 8'h30;
         {8'h0C, 8'h7C}: presetVal = 8'h02;
         {8'h0C, 8'h7F}: presetVal = 8'h02;
         {8'h0C, 8'h80}: presetVal = 8'h01;
         {8'h0C, 8'h81}: presetVal = 8'hAA;
         {8'h0C, 8'h82}: presetVal = 8'h24;
         {8'h0C, 8'h9B}: presetVal = 8'h04;
         {8'h0C, 8'h9C}: presetVal = 8'h04;
         {8'h0D, 8'h03}: presetVal = 8'h0A;
         {8'h0D, 8'h04}: presetVal = 8'h07;
         {8'h0D, 8'h23}: presetVal = 8'h00;
         {8'h0D, 8'h24}: presetVal = 8'h00;
         {8'h0D, 8'h25}: presetVal = 8'h00;
         {8'h0D, 8'h3D}: presetVal = 8'h61;
         {8'h0D, 8'h7C}: presetVal = 8'h04;
         {8'h0D, 8'h9B}: presetVal = 8'h04;
         {8'h0D, 8'h9C}: presetVal = 8'h04;
         default: hit = 1'b0;
      endcase
   end

   // Listed variables take the preset, the rest the default
   assign cvValue = hit ? presetVal : factory;
endmodule // pcl_cv_rom

// ==== core/pcl_loader.sv ====
// Preset configuration loader with its AXI4-Lite register window
// How it works
// - Presets stored; applied only on identity command
// - Identity reads maker code; writes never stored
// - Preset command: full reset, preset over defaults
// - Command 8 re-applies the remembered preset
// - Command 0 restores every factory default
// - Single variable writes still allowed afterwards
// - Out of reset: defaults, no preset active
// - Preset 10: speed, motor, analog values
// - Preset 10: regulation, braking, customer codes
// - Preset 11 value list
// - Preset 12 value list
// - Preset 13 value list
// - Sound variant refuses preset commands; command 8 still re-applies a remembered preset
// - Value bit 0 weight 1, bit 7 weight 128
//
// Our own choice: the AXI4-Lite interface to the registers.
module pcl_loader (
   input logic mclk, // 125 MHz clock
   input logic rst_n, // Synchronous reset, active low
   input logic [11:0] s_axi_awaddr, // Write address
   input logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input logic [31:0] s_axi_wdata, // Write data
   input logic [3:0] s_axi_wstrb, // Write byte strobes
   input logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input logic s_axi_bready, // Write response ready
   input logic [11:0] s_axi_araddr, // Read address
   input logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input logic s_axi_rready, // Read data ready
   input logic soundVariant, // Strap pin, high on sound variant
   input logic [7:0] nvPresetIn, // Stored preset from nonvolatile memory
   output logic [7:0] savedPreset, // Preset number to store
   output logic saveStrobe, // One-cycle pulse: store savedPreset
   output logic loaderBusy // Bank is being rewritten
);
   pcl_pkg::pcl_state_type s_r;
   pcl_pkg::pcl_state_type s_nxt;
   logic [7:0] romValue;
   logic [7:0] cmdVal;
   logic wrReady;
   logic [11:0] wrAddr;

   // True when the address falls in the variable bank window
   function automatic logic isBank(input logic [11:0] a);
      return a[11:10] == pcl_pkg::BANK_SEL;
   endfunction

   // True when the address reaches the identity variable
   function automatic logic isCmd(input logic [11:0] a);
      return (a == pcl_pkg::ADDR_CMD) ||
         (isBank(a) && (a[9:2] == pcl_pkg::CV_ID_INDEX));
   endfunction

   // True for a numbered preset that this variant offers
   function automatic logic isPreset(input logic [7:0] v,
      input logic sound);
      return !sound && (v >= pcl_pkg::PRESET_FIRST) &&
         (v <= pcl_pkg::PRESET_LAST);
   endfunction

   // Value source for the variable being loaded
   pcl_cv_rom rom (
      .presetSel(s_r.loadPreset),
      .cvIndex(s_r.idx),
      .cvValue(romValue)
   );

   // Pending write is complete and may be executed
   assign wrReady = s_r.awFull && s_r.wFull && !s_r.bValid &&
      (s_r.mode == pcl_pkg::ST_IDLE);
   assign wrAddr = s_r.awAddr;
   assign cmdVal = s_r.wData;

   // Next state of the whole block
   always_comb begin
      s_nxt = s_r;
      s_nxt.saveStrobe = 1'b0;

      // Two-stage synchronisers for the pins
      s_nxt.soundMeta = soundVariant;
      s_nxt.soundSync = s_r.soundMeta;
      s_nxt.nvMeta = nvPresetIn;
      s_nxt.nvSync = s_r.nvMeta;

      // Write address and data taken in either order
      if (s_axi_awvalid && s_r.awRdy) begin
         s_nxt.awFull = 1'b1;
         s_nxt.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_r.wRdy) begin
         s_nxt.wFull = 1'b1;
         s_nxt.wData = s_axi_wdata[7:0];
         s_nxt.wLane = s_axi_wstrb[0];
      end
      if (s_r.bValid && s_axi_bready) begin
         s_nxt.bValid = 1'b0;
      end

      // Sequencer for settling, loading and idle
      case (s_r.mode)
         pcl_pkg::ST_SETTLE: begin
            s_nxt.settle = s_r.settle + 2'h1;
            if (s_r.settle == pcl_pkg::SETTLE_LAST) begin
               // Recall remembered preset, load plain defaults
               if (isPreset(s_r.nvSync, 1'b0)) begin
                  s_nxt.lastPreset = s_r.nvSync;
               end else begin
                  s_nxt.lastPreset = pcl_pkg::NO_PRESET;
               end
               s_nxt.loadPreset = pcl_pkg::NO_PRESET;
               s_nxt.idx = 8'h00;
               s_nxt.mode = pcl_pkg::ST_LOAD;
            end
         end
         pcl_pkg::ST_LOAD: begin
            // One variable per cycle, whole bank rewritten
            s_nxt.cv[s_r.idx] = romValue;
            s_nxt.idx = s_r.idx + 8'h01;
            if (s_r.idx == pcl_pkg::LAST_INDEX) begin
               s_nxt.mode = pcl_pkg::ST_IDLE;
            end
         end
         pcl_pkg::ST_IDLE: begin
            if (wrReady) begin
               s_nxt.awFull = 1'b0;
               s_nxt.wFull = 1'b0;
               s_nxt.bValid = 1'b1;
               s_nxt.bResp = pcl_pkg::RESP_OKAY;
               if (isCmd(wrAddr)) begin
                  // Identity writes act as commands only
                  if (s_r.wLane) begin
                     if (cmdVal == pcl_pkg::CMD_FACTORY) begin
                        s_nxt.lastPreset = pcl_pkg::NO_PRESET;
                        s_nxt.saveStrobe = 1'b1;
                        s_nxt.loadPreset = pcl_pkg::NO_PRESET;
                        s_nxt.idx = 8'h00;
                        s_nxt.mode = pcl_pkg::ST_LOAD;
                     end else if (cmdVal == pcl_pkg::CMD_REAPPLY) begin
                        s_nxt.loadPreset = s_r.lastPreset;
                        s_nxt.idx = 8'h00;
                        s_nxt.mode = pcl_pkg::ST_LOAD;
                     end else if (isPreset(cmdVal, s_r.soundSync)) begin
                        s_nxt.lastPreset = cmdVal;
                        s_nxt.saveStrobe = 1'b1;
                        s_nxt.loadPreset = cmdVal;
                        s_nxt.idx = 8'h00;
                        s_nxt.mode = pcl_pkg::ST_LOAD;
                     end
                  end
               end else if (isBank(wrAddr)) begin
                  // Ordinary variable write over any preset value
                  if (s_r.wLane) begin
                     s_nxt.cv[wrAddr[9:2]] = cmdVal;
                  end
               end else if (wrAddr != pcl_pkg::ADDR_STATUS) begin
                  s_nxt.bResp = pcl_pkg::RESP_SLVERR;
               end
            end
         end
         default: begin
            s_nxt.mode = pcl_pkg::ST_IDLE;
         end
      endcase

      // Read channel: answer one cycle after the address
      if (s_r.rValid && s_axi_rready) begin
         s_nxt.rValid = 1'b0;
      end
      if (s_axi_arvalid && s_r.arRdy) begin
         s_nxt.rValid = 1'b1;
         s_nxt.rResp = pcl_pkg::RESP_OKAY;
         s_nxt.rData = 32'h0000_0000;
         if (isCmd(s_axi_araddr)) begin
            s_nxt.rData[7:0] = pcl_pkg::MAKER_CODE;
         end else if (isBank(s_axi_araddr)) begin
            s_nxt.rData[7:0] = s_r.cv[s_axi_araddr[9:2]];
         end else if (s_axi_araddr == pcl_pkg::ADDR_STATUS) begin
            s_nxt.rData[pcl_pkg::ST_BUSY_BIT] =
               (s_r.mode != pcl_pkg::ST_IDLE);
            s_nxt.rData[pcl_pkg::ST_PRESET_LSB +: 8] = s_r.lastPreset;
            s_nxt.rData[pcl_pkg::ST_SOUND_BIT] = s_r.soundSync;
         end else begin
            s_nxt.rResp = pcl_pkg::RESP_SLVERR;
         end
      end

      // Ready flags follow the holding registers
      s_nxt.awRdy = !s_nxt.awFull;
      s_nxt.wRdy = !s_nxt.wFull;
      s_nxt.arRdy = !s_nxt.rValid;

      // Synchronous reset to constants
      if (!rst_n) begin
         s_nxt = '0;
         s_nxt.mode = pcl_pkg::ST_SETTLE;
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      s_r <= s_nxt;
   end

   // Outputs straight from the state register
   assign s_axi_awready = s_r.awRdy;
   assign s_axi_wready = s_r.wRdy;
   assign s_axi_bvalid = s_r.bValid;
   assign s_axi_bresp = s_r.bResp;
   assign s_axi_arready = s_r.arRdy;
   assign s_axi_rvalid = s_r.rValid;
   assign s_axi_rdata = s_r.rData;
   assign s_axi_rresp = s_r.rResp;
   assign savedPreset = s_r.lastPreset;
   assign saveStrobe = s_r.saveStrobe;
   assign loaderBusy = (s_r.mode != pcl_pkg::ST_IDLE) ? 1'b1 : 1'b0;
endmodule // pcl_loader

// ==== core/pcl_pkg.sv ====
// Constants and types shared by the preset configuration loader
package pcl_pkg;
   // Register byte addresses on the AXI4-Lite window
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_CMD = 12'h008;
   localparam logic [1:0] BANK_SEL = 2'h1;
   // Identity variable index and command values
   localparam logic [7:0] CV_ID_INDEX = 8'h08;
   localparam logic [7:0] CMD_FACTORY = 8'h00;
   localparam logic [7:0] CMD_REAPPLY = 8'h08;
   localparam logic [7:0] PRESET_FIRST = 8'h0A;
   localparam logic [7:0] PRESET_LAST = 8'h0D;
   localparam logic [7:0] NO_PRESET = 8'h00;
   localparam logic [7:0] LAST_INDEX = 8'hFF;
   // Arbitrary maker and customer identification values
   localparam logic [7:0] MAKER_CODE = 8'h5A;
   localparam logic [7:0] CUST_ID_A = 8'h3C;
   localparam logic [7:0] CUST_ID_B = 8'h01;
   // Status register field positions
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_PRESET_LSB = 8;
   localparam int ST_SOUND_BIT = 16;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Cycles after reset before the pin sample is trusted
   localparam logic [1:0] SETTLE_LAST = 2'h2;

   typedef enum logic [1:0] {
      ST_SETTLE,
      ST_LOAD,
      ST_IDLE
   } pcl_mode_type;

   typedef struct packed {
      pcl_mode_type mode;
      logic [1:0] settle;
      logic [7:0] idx;
      logic [7:0] loadPreset;
      logic [7:0] lastPreset;
      logic saveStrobe;
      logic soundMeta;
      logic soundSync;
      logic [7:0] nvMeta;
      logic [7:0] nvSync;
      logic awRdy;
      logic awFull;
      logic [11:0] awAddr;
      logic wRdy;
      logic wFull;
      logic [7:0] wData;
      logic wLane;
      logic bValid;
      logic [1:0] bResp;
      logic arRdy;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic [255:0][7:0] cv;
   } pcl_state_type;
endpackage

// ==== test/pcl_loader_bench.sv ====
// Self-checking bench for the preset loader
module pcl_loader_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [11:0] s_axi_araddr = 12'h000;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b1;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b1;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic soundVariant = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, saveStrobe, loaderBusy;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata, rd;
   logic [7:0] nvPresetIn, savedPreset, v, n;
   int n_fail = 0;
   int n_checks = 0;
   int seed = 16593;
   logic [7:0] cvList [13] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09,
      8'h1D, 8'h38, 8'h3A, 8'h3D, 8'h69, 8'h7C, 8'h9B};

   pcl_loader DUT (
      .mclk(mclk),
      .rst_n(rst_n),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .soundVariant(soundVariant),
      .nvPresetIn(nvPresetIn),
      .savedPreset(savedPreset),
      .saveStrobe(saveStrobe),
      .loaderBusy(loaderBusy)
   );
   pcl_nv_model nv (.mclk(mclk), .savedPreset(savedPreset),
      .saveStrobe(saveStrobe), .nvPresetIn(nvPresetIn));

   initial begin
      forever #4 mclk = ~mclk;
   end

   // Expected variable value for a preset
   function automatic logic [7:0] expCv(input logic [7:0] p, input logic [7:0] i);
      logic [7:0] e;
      e = (i == 8'h01) ? 8'h03 : (i == 8'h03) ? 8'h02 :
         (i >= 8'h02 && i <= 8'h06) ? 8'h01 : (i == 8'h1D) ? 8'h04 : 8'h00;
      case (p)
         8'h0A: case (i)
            8'h02: e = 8'h04; 8'h03: e = 8'h06; 8'h04: e = 8'h02;
            8'h05: e = 8'hFC; 8'h06: e = 8'h55; 8'h09: e = 8'h5F;
            8'h1D: e = 8'h06; 8'h38: e = 8'h21; 8'h69: e = pcl_pkg::CUST_ID_A;
         endcase
         8'h0B: case (i)
            8'h03: e = 8'h03; 8'h04: e = 8'h02; 8'h09: e = 8'h58; 8'h38: e = 8'h3D;
            8'h3A: e = 8'hAA; 8'h7C: e = 8'h80;
         endcase
         8'h0C: case (i)
            8'h03: e = 8'h0F; 8'h04: e = 8'h08; 8'h06: e = 8'h78; 8'h7C: e = 8'h02;
            8'h9B: e = 8'h04;
         endcase
         8'h0D: case (i)
            8'h03: e = 8'h0A; 8'h04: e = 8'h07; 8'h3D: e = 8'h61; 8'h7C: e = 8'h04;
            8'h9B: e = 8'h04;
         endcase
         default: ;
      endcase
      return e;
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Write cycle, both channels offered together
   task automatic axWr(input logic [11:0] a, input logic [7:0] d);
      logic ta, tw, tb, bv;
      tb = 1'b0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'($random(seed));
      for (int k = 0; k < 600 && !tb; k++) begin
         @(negedge mclk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid & s_axi_bready;
         bv = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge mclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (bv) s_axi_bready <= 1'b1;
      end
      if (!tb) begin
         n_fail++;
         tally_and_finish;
      end
   endtask

   // Read cycle
   task automatic axRd(input logic [11:0] a);
      logic ta, tb, rv;
      tb = 1'b0;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'($random(seed));
      for (int k = 0; k < 600 && !tb; k++) begin
         @(negedge mclk);
         ta = s_axi_arvalid & s_axi_arready;
         tb = s_axi_rvalid & s_axi_rready;
         rv = s_axi_rvalid;
         rd = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge mclk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (rv) s_axi_rready <= 1'b1;
      end
      if (!tb) begin
         n_fail++;
         tally_and_finish;
      end
   endtask

   task automatic waitIdle;
      for (int k = 0; k < 400 && loaderBusy !== 1'b0; k++) @(negedge mclk);
      if (loaderBusy !== 1'b0) begin
         n_fail++;
         tally_and_finish;
      end
   endtask

   // Command, then status and bank compare
   task automatic cmdCheck(input logic [7:0] c, input logic [7:0] p);
      axWr(pcl_pkg::ADDR_CMD, c);
      chk({30'h0000_0000, rsp}, {30'h0000_0000, pcl_pkg::RESP_OKAY});
      waitIdle;
      axRd(pcl_pkg::ADDR_STATUS);
      chk(rd & 32'h0000_FF00, {16'h0000, p, 8'h00});
      chk({24'h00_0000, nv.stored}, {24'h00_0000, p});
      foreach (cvList[i]) begin
         axRd(12'h400 + {cvList[i], 2'b00});
         chk(rd, {24'h00_0000, expCv(p, cvList[i])});
      end
   endtask

   initial begin
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      waitIdle;
      cmdCheck(8'h05, 8'h00);
      for (int i = 10; i < 14; i++) cmdCheck(8'(i), 8'(i));
      axRd(pcl_pkg::ADDR_CMD);
      chk(rd, {24'h00_0000, pcl_pkg::MAKER_CODE});
      axWr(12'h100, 8'h55);
      chk({30'h0000_0000, rsp}, {30'h0000_0000, pcl_pkg::RESP_SLVERR});
      // Random single writes over the preset
      repeat (6) begin
         n = 8'($random(seed));
         v = 8'($random(seed));
         if (n == 8'h08) n = 8'h03;
         axWr(12'h400 + {n, 2'b00}, v);
         axRd(12'h400 + {n, 2'b00});
         chk(rd, {24'h00_0000, v});
         // Write without the low byte lane leaves the value alone
         s_axi_wstrb <= 4'hE;
         axWr(12'h400 + {n, 2'b00}, ~v);
         s_axi_wstrb <= 4'hF;
         axRd(12'h400 + {n, 2'b00});
         chk(rd, {24'h00_0000, v});
      end
      cmdCheck(pcl_pkg::CMD_REAPPLY, 8'h0D);
      // Second reset: defaults, preset recovered
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      // Busy flag stands while the bank reloads
      axRd(pcl_pkg::ADDR_STATUS);
      chk(rd & 32'h0000_0001, 32'h0000_0001);
      waitIdle;
      cvList[0] = 8'h03;
      axRd(12'h40C);
      chk(rd, 32'h0000_0002);
      cmdCheck(pcl_pkg::CMD_REAPPLY, 8'h0D);
      cmdCheck(pcl_pkg::CMD_FACTORY, 8'h00);
      soundVariant <= 1'b1;
      repeat (4) @(posedge mclk);
      cmdCheck(8'h0B, 8'h00);
      axRd(pcl_pkg::ADDR_STATUS);
      chk(rd, 32'h0001_0000);
      axRd(12'h100);
      chk({30'h0000_0000, rsp}, {30'h0000_0000, pcl_pkg::RESP_SLVERR});
      tally_and_finish;
   end
endmodule // pcl_loader_bench

// ==== test/pcl_loader_props.sv ====
// Protocol and loader checks for the preset loader
module pcl_loader_chk (
   input logic mclk, // Clock
   input logic rst_n, // Reset, active low
   input logic [11:0] s_axi_araddr, // Read address
   input logic s_axi_arvalid, // Read address valid
   input logic s_axi_arready, // Read address ready
   input logic [31:0] s_axi_rdata, // Read data
   input logic [1:0] s_axi_rresp, // Read response
   input logic s_axi_rvalid, // Read valid
   input logic s_axi_rready, // Read ready
   input logic [1:0] s_axi_bresp, // Write response
   input logic s_axi_bvalid, // Write response valid
   input logic s_axi_bready, // Write response ready
   input logic [7:0] savedPreset, // Preset to store
   input logic saveStrobe, // Store pulse
   input logic loaderBusy // Bank rewrite
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // Bus answers
   AST_RD_ONE: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_RV_HOLD: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   AST_BV_HOLD: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp dropped");
   AST_ID_READ: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h008
      |=> s_axi_rdata == {24'h00_0000, pcl_pkg::MAKER_CODE})
      else $error("identity read wrong");
   // Loading and storing
   AST_LOAD_LEN: assert property (loaderBusy |-> ##[0:300] !loaderBusy)
      else $error("load too long");
   AST_STROBE_ONE: assert property (saveStrobe |=> !saveStrobe)
      else $error("store pulse too long");
   AST_STROBE_BUSY: assert property (saveStrobe |-> loaderBusy && s_axi_bvalid)
      else $error("store without load");
   AST_SAVE_VAL: assert property (saveStrobe |-> savedPreset == 8'h00
      || (savedPreset >= 8'h0A && savedPreset <= 8'h0D))
      else $error("stored preset out of range");
   cover property (saveStrobe && savedPreset == 8'h0D);
   cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   cover property ($fell(loaderBusy));
endmodule // pcl_loader_chk

bind pcl_loader pcl_loader_chk chk (
   .mclk(mclk),
   .rst_n(rst_n),
   .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .savedPreset(savedPreset),
   .saveStrobe(saveStrobe),
   .loaderBusy(loaderBusy)
);

// ==== test/pcl_nv_model.sv ====
// Nonvolatile store model keeping the remembered preset
module pcl_nv_model (
   input logic mclk, // Clock
   input logic [7:0] savedPreset, // Value to keep
   input logic saveStrobe, // Store pulse
   output logic [7:0] nvPresetIn // Kept value
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] stored = 8'h00;
   // Value survives decoder resets
   always @(posedge mclk) if (saveStrobe) stored <= savedPreset;
   assign nvPresetIn = stored;
endmodule // pcl_nv_model
